// File: src/dic_map.svh
// Register offsets, field positions and timing counts of the input conditioner
`ifndef DIC_MAP_SVH
`define DIC_MAP_SVH

// Number of fitted inputs and trip outputs
`define DIC_N_IN        8
`define DIC_N_TRIP      8
// Register address width and data width
`define DIC_AW          8
`define DIC_DW          32

// Register offsets (byte addresses)
`define DIC_R_STATE     8'h00
`define DIC_R_POLARITY  8'h04
`define DIC_R_ON_EV_EN  8'h08
`define DIC_R_OFF_EV_EN 8'h0C
`define DIC_R_ALARM_EN  8'h10
`define DIC_R_MODE      8'h14
`define DIC_R_FORCE     8'h18
`define DIC_R_OUT_STAT  8'h1C
`define DIC_R_LATCH_CFG 8'h20
`define DIC_R_LATCH_REL 8'h24
`define DIC_R_IRQ_STAT  8'h28
`define DIC_R_IRQ_EN    8'h2C
`define DIC_R_IRQ_CLR   8'h30
`define DIC_R_DELAY0    8'h40
`define DIC_R_COUNT0    8'h80
// Spacing of the per-input delay and counter registers
`define DIC_R_STRIDE    8'h04

// Output status layout: trips in low byte, then alarm and service bits
`define DIC_OUT_ALARM   8
`define DIC_OUT_SERVICE 9
`define DIC_OUT_W       10

// Interrupt status layout: on events, off events, alarm pop-ups (one byte each)
`define DIC_IRQ_ON      0
`define DIC_IRQ_OFF     8
`define DIC_IRQ_ALM     16
`define DIC_IRQ_W       24

// Delay step of 10 ms at 100 MHz, max setting 60.00 s = 6000 steps
`define DIC_STEP_NS     10000000
`define DIC_CLK_NS      10
`define DIC_STEP_CYC    (`DIC_STEP_NS / `DIC_CLK_NS)
`define DIC_DELAY_MAX   13'h1770
`define DIC_DELAY_W     13
`define DIC_CNT_W       16
// Step divider width, wide enough for one 10 ms step
`define DIC_TICK_W      24

`endif

// File: src/dic_pkg.sv
// Types shared by the input conditioner files
`default_nettype none
package dic_pkg;
  typedef logic [12:0] delay_t;
  typedef logic [15:0] count_t;
  typedef enum logic {
    MODE_DC,
    MODE_AC
  } volt_mode_t;
endpackage : dic_pkg
`default_nettype wire

// File: src/dic_sync.sv
// Two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
`default_nettype none
module dic_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  // Level in and out
  input  wire logic pin_i,
  output logic      sync_o
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = pin_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;
endmodule : dic_sync
`default_nettype wire

// File: src/dic_channel.sv
// One conditioned input: polarity, definite delay, edge pulses and counter
`timescale 1ns/1ps
`default_nettype none
`include "dic_map.svh"
module dic_channel (
  // Clock and reset
  input  wire logic            clk_i,
  input  wire logic            sys_rst_i,
  // Synchronised pin, settings and step tick
  input  wire logic            raw_i,
  input  wire logic            polarity_nc_i,
  input  wire dic_pkg::delay_t delay_i,
  input  wire logic            tick_i,
  // Counter write
  input  wire logic            cnt_we_i,
  input  wire dic_pkg::count_t cnt_wdata_i,
  // Results
  output logic                 state_o,
  output logic                 act_edge_o,
  output logic                 inact_edge_o,
  output dic_pkg::count_t      count_o
);
  logic            state_q;
  logic            state_d;
  dic_pkg::delay_t timer_q;
  dic_pkg::delay_t timer_d;
  dic_pkg::count_t count_q;
  dic_pkg::count_t count_d;
  logic            act_q;
  logic            act_d;
  logic            inact_q;
  logic            inact_d;
  logic            level;

  always_comb begin
    level   = raw_i ^ polarity_nc_i;
    state_d = state_q;
    timer_d = timer_q;
    count_d = count_q;
    act_d   = 1'b0;
    inact_d = 1'b0;
    if (level == state_q) begin
      timer_d = '0;
    end else if (timer_q >= delay_i) begin
      state_d = level;
      timer_d = '0;
      act_d   = level;
      inact_d = ~level;
    end else if (tick_i) begin
      timer_d = timer_q + 13'h0001;
    end
    if (cnt_we_i) begin
      count_d = cnt_wdata_i;
    end else if (act_d) begin
      count_d = count_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= 1'b0;
      timer_q <= '0;
      count_q <= '0;
      act_q   <= 1'b0;
      inact_q <= 1'b0;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      count_q <= count_d;
      act_q   <= act_d;
      inact_q <= inact_d;
    end
  end

  assign state_o      = state_q;
  assign act_edge_o   = act_q;
  assign inact_edge_o = inact_q;
  assign count_o      = count_q;
endmodule : dic_channel
`default_nettype wire

// File: src/digital_input_conditioner.sv
// Binary input conditioner and output status top with register port
`timescale 1ns/1ps
`default_nettype none
`include "dic_map.svh"
// Summary of operation
// - Normally open input: low to high is the active edge.
// - Normally closed input: high to low is the active edge.
// - One delay, 0 to 60 s in 10 ms steps, for both transitions.
// - Conditioned state per input readable, one means active.
// - Active-edge event only when its enable bit is on.
// - Inactive-edge event only when its enable bit is on.
// - Alarm indication at active edge when alarm display is enabled.
// - Per-input active-edge counter 0..65535, writable by software.
// - Device-wide voltage mode setting, dc or ac.
// - Readable status bit for each trip, alarm and service output.
// - Test force flag, settable on or off.
// - Output status writes act only while force flag is on.
// - Each output non-latched or latched until a latch release.
module digital_input_conditioner (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    sys_rst_i,
  // Field contacts
  input  wire logic [`DIC_N_IN-1:0]    binary_input_n_i,
  // Controlling signals from protection logic
  input  wire logic [`DIC_OUT_W-1:0]   out_ctrl_i,
  // Register port
  input  wire logic [`DIC_AW-1:0]      reg_addr_i,
  input  wire logic [`DIC_DW-1:0]      reg_wdata_i,
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  output logic [`DIC_DW-1:0]           reg_rdata_o,
  // Output coils
  output logic [`DIC_N_TRIP-1:0]       trip_output_n_o,
  output logic                         alarm_signal_output_o,
  output logic                         service_status_output_o,
  // Conditioned inputs, events and interrupt
  output logic [`DIC_N_IN-1:0]         input_state_o,
  output logic [`DIC_N_IN-1:0]         on_event_o,
  output logic [`DIC_N_IN-1:0]         off_event_o,
  output logic                         alarm_popup_o,
  output logic                         volt_mode_ac_o,
  output logic                         irq_o
);
  localparam int STEP_CYC = `DIC_STEP_CYC;
  localparam int TICK_W   = `DIC_TICK_W;

  // Settings
  logic [`DIC_N_IN-1:0]   pol_q;
  logic [`DIC_N_IN-1:0]   pol_d;
  logic [`DIC_N_IN-1:0]   on_en_q;
  logic [`DIC_N_IN-1:0]   on_en_d;
  logic [`DIC_N_IN-1:0]   off_en_q;
  logic [`DIC_N_IN-1:0]   off_en_d;
  logic [`DIC_N_IN-1:0]   alm_en_q;
  logic [`DIC_N_IN-1:0]   alm_en_d;
  dic_pkg::volt_mode_t    mode_q;
  dic_pkg::volt_mode_t    mode_d;
  logic                   force_q;
  logic                   force_d;
  logic [`DIC_OUT_W-1:0]  forced_q;
  logic [`DIC_OUT_W-1:0]  forced_d;
  logic [`DIC_OUT_W-1:0]  latch_cfg_q;
  logic [`DIC_OUT_W-1:0]  latch_cfg_d;
  // Coil drive and per-input delays
  logic [`DIC_OUT_W-1:0]  latched_q;
  logic [`DIC_OUT_W-1:0]  latched_d;
  logic [`DIC_OUT_W-1:0]  out_q;
  logic [`DIC_OUT_W-1:0]  out_d;
  dic_pkg::delay_t        delay_q [`DIC_N_IN];
  dic_pkg::delay_t        delay_d [`DIC_N_IN];
  // Events and interrupt
  logic [`DIC_IRQ_W-1:0]  ist_q;
  logic [`DIC_IRQ_W-1:0]  ist_d;
  logic [`DIC_IRQ_W-1:0]  ien_q;
  logic [`DIC_IRQ_W-1:0]  ien_d;
  logic                   irq_q;
  logic                   irq_d;
  logic [`DIC_N_IN-1:0]   on_ev_q;
  logic [`DIC_N_IN-1:0]   on_ev_d;
  logic [`DIC_N_IN-1:0]   off_ev_q;
  logic [`DIC_N_IN-1:0]   off_ev_d;
  logic                   popup_q;
  logic                   popup_d;
  // Read data and step divider
  logic [`DIC_DW-1:0]     rdata_q;
  logic [`DIC_DW-1:0]     rdata_d;
  logic [TICK_W-1:0]      tick_cnt_q;
  logic [TICK_W-1:0]      tick_cnt_d;
  logic                   tick;

  // Channel results
  logic [`DIC_N_IN-1:0]   raw_s;
  logic [`DIC_N_IN-1:0]   state_s;
  logic [`DIC_N_IN-1:0]   act_s;
  logic [`DIC_N_IN-1:0]   inact_s;
  logic [`DIC_N_IN-1:0]   cnt_we;
  dic_pkg::count_t        count_s [`DIC_N_IN];

  genvar g;
  generate
    for (g = 0; g < `DIC_N_IN; g++) begin : g_in
      dic_sync u_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (binary_input_n_i[g]),
        .sync_o    (raw_s[g])
      );
      assign cnt_we[g] = reg_wr_i &&
                         (reg_addr_i == (`DIC_R_COUNT0 + 8'(`DIC_R_STRIDE * g)));
      dic_channel u_ch (
        .clk_i         (clk_i),
        .sys_rst_i     (sys_rst_i),
        .raw_i         (raw_s[g]),
        .polarity_nc_i (pol_q[g]),
        .delay_i       (delay_q[g]),
        .tick_i        (tick),
        .cnt_we_i      (cnt_we[g]),
        .cnt_wdata_i   (reg_wdata_i[`DIC_CNT_W-1:0]),
        .state_o       (state_s[g]),
        .act_edge_o    (act_s[g]),
        .inact_edge_o  (inact_s[g]),
        .count_o       (count_s[g])
      );
    end
  endgenerate

  // Step tick every 10 ms for the delay timers
  assign tick = (tick_cnt_q == TICK_W'(STEP_CYC - 1));

  always_comb begin
    tick_cnt_d = tick ? '0 : tick_cnt_q + TICK_W'(1'h1);
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
    end
  end

  // Settings, latches and interrupt status
  always_comb begin
    pol_d       = pol_q;
    on_en_d     = on_en_q;
    off_en_d    = off_en_q;
    alm_en_d    = alm_en_q;
    mode_d      = mode_q;
    force_d     = force_q;
    forced_d    = forced_q;
    latch_cfg_d = latch_cfg_q;
    ien_d       = ien_q;
    delay_d     = delay_q;
    latched_d   = latched_q;
    ist_d       = ist_q;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `DIC_R_POLARITY:  pol_d    = reg_wdata_i[`DIC_N_IN-1:0];
        `DIC_R_ON_EV_EN:  on_en_d  = reg_wdata_i[`DIC_N_IN-1:0];
        `DIC_R_OFF_EV_EN: off_en_d = reg_wdata_i[`DIC_N_IN-1:0];
        `DIC_R_ALARM_EN:  alm_en_d = reg_wdata_i[`DIC_N_IN-1:0];
        `DIC_R_MODE:      mode_d   = dic_pkg::volt_mode_t'(reg_wdata_i[0]);
        `DIC_R_FORCE:     force_d  = reg_wdata_i[0];
        `DIC_R_OUT_STAT: begin
          if (force_q) begin
            forced_d = reg_wdata_i[`DIC_OUT_W-1:0];
          end
        end
        `DIC_R_LATCH_CFG: latch_cfg_d = reg_wdata_i[`DIC_OUT_W-1:0];
        `DIC_R_LATCH_REL: latched_d   = '0;
        `DIC_R_IRQ_EN:    ien_d       = reg_wdata_i[`DIC_IRQ_W-1:0];
        `DIC_R_IRQ_CLR:   ist_d       = ist_q & ~reg_wdata_i[`DIC_IRQ_W-1:0];
        default: ;
      endcase
      for (int i = 0; i < `DIC_N_IN; i++) begin
        if (reg_addr_i == (`DIC_R_DELAY0 + 8'(`DIC_R_STRIDE * i))) begin
          delay_d[i] = (reg_wdata_i[`DIC_DELAY_W-1:0] > `DIC_DELAY_MAX) ?
                       `DIC_DELAY_MAX : reg_wdata_i[`DIC_DELAY_W-1:0];
        end
      end
    end
    latched_d = latched_d | (out_ctrl_i & latch_cfg_q);
    // Set wins over a same-cycle clear
    ist_d     = ist_d | {act_s & alm_en_q, off_ev_d, on_ev_d};
    irq_d     = |(ist_d & ien_d);
  end

  // coil drive; forcing hides followed and latched bits
  always_comb begin
    out_d = force_q ? forced_q : ((out_ctrl_i & ~latch_cfg_q) | latched_q);
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  // Edge pulses, one cycle after the conditioned state moves
  always_comb begin
    on_ev_d  = act_s & on_en_q;
    off_ev_d = inact_s & off_en_q;
    popup_d  = |(act_s & alm_en_q);
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      on_ev_q  <= '0;
      off_ev_q <= '0;
      popup_q  <= 1'b0;
    end else begin
      on_ev_q  <= on_ev_d;
      off_ev_q <= off_ev_d;
      popup_q  <= popup_d;
    end
  end

  // Read data stand one cycle after the strobe, zero otherwise
  always_comb begin
    rdata_d = '0;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `DIC_R_STATE:     rdata_d = 32'(state_s);
        `DIC_R_POLARITY:  rdata_d = 32'(pol_q);
        `DIC_R_ON_EV_EN:  rdata_d = 32'(on_en_q);
        `DIC_R_OFF_EV_EN: rdata_d = 32'(off_en_q);
        `DIC_R_ALARM_EN:  rdata_d = 32'(alm_en_q);
        `DIC_R_MODE:      rdata_d = 32'(mode_q);
        `DIC_R_FORCE:     rdata_d = 32'(force_q);
        `DIC_R_OUT_STAT:  rdata_d = 32'(out_q);
        `DIC_R_LATCH_CFG: rdata_d = 32'(latch_cfg_q);
        `DIC_R_IRQ_STAT:  rdata_d = 32'(ist_q);
        `DIC_R_IRQ_EN:    rdata_d = 32'(ien_q);
        default: ;
      endcase
      for (int i = 0; i < `DIC_N_IN; i++) begin
        if (reg_addr_i == (`DIC_R_DELAY0 + 8'(`DIC_R_STRIDE * i))) begin
          rdata_d = 32'(delay_q[i]);
        end
        if (reg_addr_i == (`DIC_R_COUNT0 + 8'(`DIC_R_STRIDE * i))) begin
          rdata_d = 32'(count_s[i]);
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pol_q       <= '0;
      on_en_q     <= '0;
      off_en_q    <= '0;
      alm_en_q    <= '0;
      mode_q      <= dic_pkg::MODE_DC;
      force_q     <= 1'b0;
      forced_q    <= '0;
      latch_cfg_q <= '0;
      latched_q   <= '0;
      ien_q       <= '0;
      ist_q       <= '0;
      irq_q       <= 1'b0;
      for (int i = 0; i < `DIC_N_IN; i++) begin
        delay_q[i] <= '0;
      end
    end else begin
      pol_q       <= pol_d;
      on_en_q     <= on_en_d;
      off_en_q    <= off_en_d;
      alm_en_q    <= alm_en_d;
      mode_q      <= mode_d;
      force_q     <= force_d;
      forced_q    <= forced_d;
      latch_cfg_q <= latch_cfg_d;
      latched_q   <= latched_d;
      ien_q       <= ien_d;
      ist_q       <= ist_d;
      irq_q       <= irq_d;
      delay_q     <= delay_d;
    end
  end

  // Input state is already a channel flip-flop
  assign input_state_o           = state_s;
  assign reg_rdata_o             = rdata_q;
  assign trip_output_n_o         = out_q[`DIC_N_TRIP-1:0];
  assign alarm_signal_output_o   = out_q[`DIC_OUT_ALARM];
  assign service_status_output_o = out_q[`DIC_OUT_SERVICE];
  assign on_event_o              = on_ev_q;
  assign off_event_o             = off_ev_q;
  assign alarm_popup_o           = popup_q;
  assign volt_mode_ac_o          = 1'(mode_q);
  assign irq_o                   = irq_q;
endmodule : digital_input_conditioner
`default_nettype wire

// File: dv/dic_sva.sv
// Port checker for the input conditioner, bound to its top
`timescale 1ns/1ps
`default_nettype none
`include "dic_map.svh"
module dic_sva (
  // Clock and reset
  input wire logic                   clk_i,
  input wire logic                   sys_rst_i,
  // Controls and register port
  input wire logic [`DIC_OUT_W-1:0]  out_ctrl_i,
  input wire logic [`DIC_AW-1:0]     reg_addr_i,
  input wire logic [`DIC_DW-1:0]     reg_wdata_i,
  input wire logic                   reg_wr_i,
  input wire logic                   reg_rd_i,
  input wire logic [`DIC_DW-1:0]     reg_rdata_o,
  // Outputs
  input wire logic [`DIC_N_TRIP-1:0] trip_output_n_o,
  input wire logic                   alarm_signal_output_o,
  input wire logic                   service_status_output_o,
  input wire logic [`DIC_N_IN-1:0]   input_state_o,
  input wire logic [`DIC_N_IN-1:0]   on_event_o,
  input wire logic [`DIC_N_IN-1:0]   off_event_o,
  input wire logic                   alarm_popup_o,
  input wire logic                   volt_mode_ac_o
);
  logic                  force_q, force_d;
  logic [`DIC_OUT_W-1:0] ctrl_q, ctrl_d, outs;
  logic [1:0]            quiet_q, quiet_d;
  assign outs = {service_status_output_o, alarm_signal_output_o, trip_output_n_o};
  // Cycles since a legal cause; a status write with force off is no cause
  always_comb begin
    force_d = force_q;
    ctrl_d  = out_ctrl_i;
    quiet_d = (quiet_q == 2'h3) ? 2'h3 : quiet_q + 2'h1;
    if (reg_wr_i && reg_addr_i == `DIC_R_FORCE)
      force_d = reg_wdata_i[0];
    if (ctrl_q != out_ctrl_i || (reg_wr_i && (reg_addr_i != `DIC_R_OUT_STAT || force_q)))
      quiet_d = 2'h0;
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      force_q <= 1'b0;
      ctrl_q  <= '0;
      quiet_q <= 2'h0;
    end else begin
      force_q <= force_d;
      ctrl_q  <= ctrl_d;
      quiet_q <= quiet_d;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_rd_idle_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
    else $error("read data not zero outside answer");
  chk_on_ev_edge: assert property ((on_event_o & ~($past(input_state_o)
      & ~$past(input_state_o, 2))) == '0) else $error("on event without active edge");
  chk_off_ev_edge: assert property ((off_event_o & ~(~$past(input_state_o)
      & $past(input_state_o, 2))) == '0) else $error("off event without inactive edge");
  chk_alarm_at_edge: assert property (alarm_popup_o |->
      |($past(input_state_o) & ~$past(input_state_o, 2))) else $error("popup without edge");
  chk_on_ev_pulse: assert property ((on_event_o & $past(on_event_o)) == '0)
    else $error("on event longer than one cycle");
  chk_off_ev_pulse: assert property ((off_event_o & $past(off_event_o)) == '0)
    else $error("off event longer than one cycle");
  chk_out_quiet_hold: assert property (quiet_q == 2'h3 |-> $stable(outs))
    else $error("outputs moved without cause");
  chk_mode_by_write: assert property ($changed(volt_mode_ac_o) |->
      ($past(reg_wr_i) && $past(reg_addr_i) == `DIC_R_MODE)
      || ($past(reg_wr_i, 2) && $past(reg_addr_i, 2) == `DIC_R_MODE))
    else $error("mode changed without write");
endmodule : dic_sva
bind digital_input_conditioner dic_sva chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .out_ctrl_i(out_ctrl_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .trip_output_n_o(trip_output_n_o),
  .alarm_signal_output_o(alarm_signal_output_o),
  .service_status_output_o(service_status_output_o), .input_state_o(input_state_o),
  .on_event_o(on_event_o), .off_event_o(off_event_o), .alarm_popup_o(alarm_popup_o),
  .volt_mode_ac_o(volt_mode_ac_o)
);
`default_nettype wire

// File: dv/field_model.sv
// Field side: contact wiring into the inputs and coil view of the outputs
`timescale 1ns/1ps
`default_nettype none
`include "dic_map.svh"
module field_model (
  // Contact closures from the bench
  input  wire logic [`DIC_N_IN-1:0]   closed_i,
  // Coils driven by the block
  input  wire logic [`DIC_N_TRIP-1:0] trip_i,
  input  wire logic                   alarm_i,
  input  wire logic                   service_i,
  // Pin levels and coil states
  output logic      [`DIC_N_IN-1:0]   pin_o,
  output logic      [`DIC_OUT_W-1:0]  coil_o
);
  // Bounce-free contacts: glitches are made by the bench on purpose
  assign pin_o  = closed_i;
  assign coil_o = {service_i, alarm_i, trip_i};
endmodule : field_model
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the input conditioner
`timescale 1ns/1ps
`default_nettype none
`include "dic_map.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb_top;
  logic                   clk_i = 1'b0;
  logic                   sys_rst_i = 1'b1;
  logic [`DIC_N_IN-1:0]   closed = 8'h00;
  logic [`DIC_OUT_W-1:0]  ctrl = 10'h000;
  logic [`DIC_AW-1:0]     addr = 8'h00;
  logic [`DIC_DW-1:0]     wdata = 32'h0;
  logic                   wr = 1'b0;
  logic                   rd = 1'b0;
  logic [`DIC_DW-1:0]     rdata;
  logic [`DIC_N_IN-1:0]   pins, state, on_ev, off_ev, on_seen = 8'h00, off_seen = 8'h00;
  logic [`DIC_N_TRIP-1:0] trip;
  logic [`DIC_OUT_W-1:0]  coils;
  logic                   alarm, service, popup, popup_seen = 1'b0, mode_ac, irq;
  int                     fails = 0;
  int                     num_checks = 0;
  int                     cyc = 0;
  field_model field (.closed_i(closed), .trip_i(trip), .alarm_i(alarm),
    .service_i(service), .pin_o(pins), .coil_o(coils));
  digital_input_conditioner dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .binary_input_n_i(pins), .out_ctrl_i(ctrl), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .trip_output_n_o(trip),
    .alarm_signal_output_o(alarm), .service_status_output_o(service),
    .input_state_o(state), .on_event_o(on_ev), .off_event_o(off_ev),
    .alarm_popup_o(popup), .volt_mode_ac_o(mode_ac), .irq_o(irq));
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    on_seen    <= on_seen | on_ev;
    off_seen   <= off_seen | off_ev;
    popup_seen <= popup_seen | popup;
  end
  task automatic summarize();
    if (fails == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  task automatic settle();
    repeat (8) @(posedge clk_i);
  endtask : settle
  task automatic wr_reg(input logic [`DIC_AW-1:0] a, input logic [`DIC_DW-1:0] d);
    @(posedge clk_i);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk_i);
    wr    <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [`DIC_AW-1:0] a, input logic [`DIC_DW-1:0] e);
    @(posedge clk_i);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    rd   <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask : rd_chk
  task automatic set_pins(input logic [`DIC_N_IN-1:0] v);
    @(posedge clk_i);
    closed <= v;
    settle();
  endtask : set_pins
  initial begin
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd_chk(`DIC_R_STATE, 32'h0);
    rd_chk(8'hFC, 32'h0);
    wr_reg(`DIC_R_ON_EV_EN, 32'h3);
    wr_reg(`DIC_R_OFF_EV_EN, 32'h1);
    wr_reg(`DIC_R_ALARM_EN, 32'h1);
    wr_reg(`DIC_R_IRQ_EN, 32'h1);
    for (int i = 0; i < `DIC_N_IN; i++)
      wr_reg(`DIC_R_DELAY0 + 8'(4 * i), 32'h0);
    // Open pin on a normally closed input reads active
    wr_reg(`DIC_R_POLARITY, 32'h2);
    settle();
    rd_chk(`DIC_R_POLARITY, 32'h2);
    rd_chk(`DIC_R_STATE, 32'h2);
    set_pins(8'h02);
    rd_chk(`DIC_R_STATE, 32'h0);
    set_pins(8'h00);
    rd_chk(`DIC_R_COUNT0 + 8'h4, 32'h2);
    `CHK(off_seen, 8'h00)
    `CHK(popup_seen, 1'b0)
    `CHK(irq, 1'b0)
    set_pins(8'h01);
    `CHK(state, 8'h03)
    `CHK(on_seen, 8'h03)
    `CHK(popup_seen, 1'b1)
    `CHK(irq, 1'b1)
    rd_chk(`DIC_R_COUNT0, 32'h1);
    set_pins(8'h00);
    `CHK(off_seen, 8'h01)
    set_pins(8'h04);
    set_pins(8'h00);
    `CHK(on_seen, 8'h03)
    rd_chk(`DIC_R_COUNT0 + 8'h8, 32'h1);
    wr_reg(`DIC_R_IRQ_CLR, 32'hFF_FFFF);
    settle();
    `CHK(irq, 1'b0)
    rd_chk(`DIC_R_IRQ_STAT, 32'h0);
    wr_reg(`DIC_R_COUNT0 + 8'hC, 32'hFFFF);
    rd_chk(`DIC_R_COUNT0 + 8'hC, 32'hFFFF);
    set_pins(8'h08);
    rd_chk(`DIC_R_COUNT0 + 8'hC, 32'h0);
    set_pins(8'h00);
    wr_reg(`DIC_R_DELAY0 + 8'h10, 32'h1FFF);
    rd_chk(`DIC_R_DELAY0 + 8'h10, 32'h1770);
    // A short glitch against a one-step delay must leave no trace
    wr_reg(`DIC_R_DELAY0 + 8'h10, 32'h1);
    set_pins(8'h10);
    repeat (40) @(posedge clk_i);
    `CHK(state, 8'h02)
    set_pins(8'h00);
    rd_chk(`DIC_R_COUNT0 + 8'h10, 32'h0);
    `CHK(state, 8'h02)
    wr_reg(`DIC_R_MODE, 32'h1);
    settle();
    `CHK(mode_ac, 1'b1)
    rd_chk(`DIC_R_MODE, 32'h1);
    @(posedge clk_i);
    ctrl <= 10'h005;
    settle();
    `CHK(coils, 10'h005)
    rd_chk(`DIC_R_OUT_STAT, 32'h5);
    wr_reg(`DIC_R_OUT_STAT, 32'h3FF);
    settle();
    `CHK(coils, 10'h005)
    wr_reg(`DIC_R_FORCE, 32'h1);
    rd_chk(`DIC_R_FORCE, 32'h1);
    wr_reg(`DIC_R_OUT_STAT, 32'h2F0);
    settle();
    `CHK(coils, 10'h2F0)
    wr_reg(`DIC_R_FORCE, 32'h0);
    settle();
    `CHK(coils, 10'h005)
    wr_reg(`DIC_R_LATCH_CFG, 32'h1);
    @(posedge clk_i);
    ctrl <= 10'h000;
    settle();
    `CHK(coils, 10'h001)
    wr_reg(`DIC_R_LATCH_REL, 32'h0);
    settle();
    `CHK(coils, 10'h000)
    summarize();
  end
endmodule : tb_top
`default_nettype wire
